// ---- rtl/acq_trig_defines.svh ----
// offsets, field positions, codes and sizes for the acquisition trigger control
// assumes an 8-bit APB byte address with one 32-bit word per register
`ifndef ACQ_TRIG_DEFINES_SVH
`define ACQ_TRIG_DEFINES_SVH
// register byte offsets
`define REG_CTRL      8'h00
`define REG_TRIGCFG   8'h04
`define REG_CHANCFG   8'h08
`define REG_THRLVL    8'h0C
`define REG_POSTCNT   8'h10
`define REG_BUFLEN    8'h14
`define REG_BUFPOST   8'h18
`define REG_STATUS    8'h1C
`define REG_FIFODATA  8'h20
`define REG_FIFOLVL   8'h24
// control and status bit positions
`define CTRL_START    0
`define CTRL_ABORT    1
`define CTRL_SLAVE    2
`define STAT_FULL     4
`define STAT_OVR      5
// trigger source codes (reference code zero means no reference trigger)
`define SRC_SW        2'h0
`define SRC_EXT       2'h1
`define SRC_THR       2'h2
`define SRC_SYNC      2'h3
`define REF_NONE      2'h0
// sample format and fifo sizing
`define NUM_CH        3
`define RAW_W         26
`define SAMPLE_W      24
`define FIFO_AW       13
`define FIFO_DEPTH    14'h2000
`define SAT_POS       26'sh07FFFFF
`define SAT_NEG       (-26'sh0800000)
`define CODE_POS_FS   24'hFFFFFF
`define CODE_NEG_FS   24'h000000
`define STATE_RST     '0
`endif

// ---- rtl/acq_trig_pkg.sv ----
// types shared by the acquisition trigger control
// assumes acq_trig_defines.svh is on the include path
`include "acq_trig_defines.svh"
package acq_trig_pkg;
	// acquisition phase
	typedef enum logic [2:0] {ST_IDLE, ST_ARMED, ST_PRE, ST_POST, ST_STOP} acq_e;

	// one scan of raw signed converter words, all channels at once
	typedef struct packed {
		logic [`NUM_CH-1:0][`RAW_W-1:0] raw;
	} adc_scan_s;

	// state of the control block apart from the fifo memory and memQ
	typedef struct packed {
		acq_e                             phase;
		logic                             extS1, extS2, extS3;
		logic                             syncPrev;
		logic                             slaveMode;
		logic [1:0]                       startSrc, refSrc;
		logic                             startPol, refPol;
		logic [`NUM_CH-1:0]               chanMask;
		logic [1:0]                       thrChan;
		logic [`SAMPLE_W-1:0]             thrLevel;
		logic                             thrPrevValid, thrPrevAbove, thrPrevBelow;
		logic                             refPend;
		logic [31:0]                      postCount, postDone;
		logic [31:0]                      bufLen, bufFill;
		logic [15:0]                      bufAvail;
		logic                             fullFlag, ovrFlag;
		logic [`NUM_CH-1:0][`SAMPLE_W-1:0] scan;
		logic [`NUM_CH-1:0]               pushLeft;
		logic [`FIFO_AW-1:0]              wrPtr, rdPtr;
		logic [`FIFO_AW:0]                count;
		logic                             headOk;
		logic [31:0]                      prdata;
		logic                             pready, pslverr;
		logic                             bufferFullEvt, overrunEvt, syncTrigOut, acqActive;
	} state_s;
endpackage

// ---- rtl/acquisition_trigger_control.sv ----
// trigger sequencing, sample encoding and input fifo for the analog input path
// assumes an APB master on mclk, scanTick pulses one cycle per sample clock,
// and all inputs synchronous to mclk except extTrig, which is resynchronised
//
// Notes on behaviour
// R1: software start write is the start event
// R2: external start on rising or falling edge
// R3: slave takes trigger from link, ignores pin
// R4: threshold fires on crossing in chosen direction
// R5: host picks one listed threshold channel
// R6: host keeps threshold level in range
// R7: host shares threshold channel and level
// R8: slave start ignores all non-link sources
// R9: external edge as reference trigger
// R10: link trigger ends pre-trigger in slave
// R11: samples are 24-bit offset binary
// R12: out-of-range inputs saturate to end codes
// R13: signal buffer-full on each filled buffer
// R14: gap-free buffers, stop when none left
// R15: host should post at least two buffers
// R16: eight thousand sample input fifo
// R17: report overrun when fifo space runs out
// R18: overrun stops acquiring and transferring
// R19: post-trigger capture starts with next sample
// R20: trigger sample not counted; stop at count
// R21: all listed channels sampled per clock
// R22: resync pin; one fire per trigger stage
`timescale 1ns/10ps
module acquisition_trigger_control
	import acq_trig_pkg::*;
(
	// clock and reset
	input  wire logic               mclk,
	input  wire logic               sys_rst,
	// apb slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	input  wire logic [3:0]         pstrb,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	// converter side
	input  wire logic               scanTick,
	input  wire adc_scan_s          adcScan,
	// trigger pins and link
	input  wire logic               extTrig,
	input  wire logic               syncLinkTrig,
	output logic                    syncTrigOut,
	// host events and status
	output logic                    bufferFullEvt,
	output logic                    overrunEvt,
	output logic                    acqActive
);

	state_s                        st;        // registered state
	state_s                        next_st;   // next state
	logic [`SAMPLE_W-1:0]          fifoMem [0:(1<<`FIFO_AW)-1]; // sample store
	logic [`SAMPLE_W-1:0]          memQ;      // word at read pointer, one cycle late
	logic                          memWe;     // fifo write strobe
	logic [`NUM_CH-1:0][`SAMPLE_W-1:0] conv;  // encoded scan

	// clamp a raw signed word and flip its sign bit into offset binary
	function automatic logic [`SAMPLE_W-1:0] toOffsetBinary(input logic [`RAW_W-1:0] raw);
		logic signed [`RAW_W-1:0] v;
		v = signed'(raw);
		if (v > `SAT_POS) begin
			return `CODE_POS_FS; // R12
		end else if (v < `SAT_NEG) begin
			return `CODE_NEG_FS; // R12
		end
		return {~v[`SAMPLE_W-1], v[`SAMPLE_W-2:0]}; // R11
	endfunction

	// threshold crossing since the previous scan
	function automatic logic crossed(input logic pol, input logic valid, input logic pa,
		input logic pb, input logic a, input logic b);
		return valid & (pol ? (~pa & a) : (~pb & b)); // R4
	endfunction

	// byte-lane merge for apb writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		return (old & ~m) | (wd & m);
	endfunction

	// every channel converted in parallel from the same scan
	for (genvar g = 0; g < `NUM_CH; g++) begin : g_conv
		assign conv[g] = toOffsetBinary(adcScan.raw[g]); // R21
	end

	// fifo memory; no reset on the array keeps it a plain ram
	always_ff @(posedge mclk) begin
		if (memWe) begin
			fifoMem[st.wrPtr] <= st.scan[lowIdx(st.pushLeft)]; // R16
		end
		memQ <= fifoMem[st.rdPtr];
	end

	// lowest pending channel of the scan being stored
	function automatic logic [1:0] lowIdx(input logic [`NUM_CH-1:0] m);
		for (int i = 0; i < `NUM_CH; i++) begin
			if (m[i]) begin
				return 2'(i);
			end
		end
		return 2'h0;
	endfunction

	// next-state logic for the whole block
	always_comb begin
		logic [31:0]          wv;
		logic                 startCmd, abortCmd, answering, wrDone, pop, push;
		logic                 extRise, extFall, syncEdge, extStartEv, extRefEv;
		logic [`SAMPLE_W-1:0] thrVal;
		logic                 above, below, startEv, refNow, refLater, accept, halt;
		wv         = '0;
		startCmd   = 1'b0;
		abortCmd   = 1'b0;
		pop        = 1'b0;
		push       = 1'b0;
		startEv    = 1'b0;
		accept     = 1'b0;
		halt       = 1'b0;
		memWe      = 1'b0;
		next_st    = st;
		// pulses last one cycle
		next_st.bufferFullEvt = 1'b0;
		next_st.overrunEvt    = 1'b0;
		next_st.syncTrigOut   = 1'b0;
		next_st.pslverr       = 1'b0;
		// pin resync; only stage two and three feed the edge detector
		next_st.extS1    = extTrig; // R22
		next_st.extS2    = st.extS1;
		next_st.extS3    = st.extS2;
		next_st.syncPrev = syncLinkTrig;
		// lagged so memQ has caught up with any write to the head
		next_st.headOk   = (st.count != '0);

		extRise    = st.extS2 & ~st.extS3;
		extFall    = ~st.extS2 & st.extS3;
		syncEdge   = syncLinkTrig & ~st.syncPrev;
		// a slave never looks at the pin
		extStartEv = ~st.slaveMode & (st.startPol ? extRise : extFall); // R2 R3
		extRefEv   = ~st.slaveMode & (st.refPol ? extRise : extFall);   // R9 R3
		// unused channel code reads as zero
		thrVal     = (st.thrChan == 2'h3) ? `CODE_NEG_FS : conv[st.thrChan];
		above      = thrVal > st.thrLevel;
		below      = thrVal < st.thrLevel;
		refNow     = (st.refSrc == `SRC_THR) & scanTick & crossed(st.refPol, st.thrPrevValid,
			st.thrPrevAbove, st.thrPrevBelow, above, below);
		refLater   = ((st.refSrc == `SRC_EXT) & extRefEv) |
			((st.refSrc == `SRC_SYNC) & syncEdge); // R10

		// apb: one wait cycle, answer registered, write lands at completion
		answering      = psel & penable & ~st.pready;
		wrDone         = psel & penable & st.pready & pwrite;
		next_st.pready = answering;
		if (answering) begin
			next_st.pslverr = 1'b0;
			next_st.prdata  = '0;
			case (paddr)
				`REG_CTRL:     next_st.prdata[`CTRL_SLAVE] = st.slaveMode;
				`REG_TRIGCFG:  next_st.prdata = {25'h0, st.refPol, st.refSrc, 1'b0,
					st.startPol, st.startSrc};
				`REG_CHANCFG:  next_st.prdata = {26'h0, st.thrChan, 1'b0, st.chanMask};
				`REG_THRLVL:   next_st.prdata = {8'h0, st.thrLevel};
				`REG_POSTCNT:  next_st.prdata = st.postCount;
				`REG_BUFLEN:   next_st.prdata = st.bufLen;
				`REG_BUFPOST:  next_st.prdata = {16'h0, st.bufAvail};
				`REG_STATUS:   next_st.prdata = {26'h0, st.ovrFlag, st.fullFlag, 1'b0,
					3'(st.phase)};
				`REG_FIFODATA: begin
					// transfers halt after an overrun
					if (!pwrite && st.headOk && !st.ovrFlag) begin // R18
						next_st.prdata = {8'h0, memQ};
						pop            = 1'b1;
					end
				end
				`REG_FIFOLVL:  next_st.prdata = {18'h0, st.count};
				default:       next_st.pslverr = 1'b1;
			endcase
		end
		if (wrDone) begin
			case (paddr)
				`REG_CTRL: begin
					wv                = merge(32'h0, pwdata, pstrb);
					startCmd          = wv[`CTRL_START]; // R1
					abortCmd          = wv[`CTRL_ABORT];
					next_st.slaveMode = pstrb[0] ? wv[`CTRL_SLAVE] : st.slaveMode;
				end
				`REG_TRIGCFG: begin
					wv               = merge({25'h0, st.refPol, st.refSrc, 1'b0, st.startPol,
						st.startSrc}, pwdata, pstrb);
					next_st.startSrc = wv[1:0];
					next_st.startPol = wv[2];
					next_st.refSrc   = wv[5:4];
					next_st.refPol   = wv[6];
				end
				`REG_CHANCFG: begin
					wv               = merge({26'h0, st.thrChan, 1'b0, st.chanMask}, pwdata,
						pstrb);
					next_st.chanMask = wv[2:0];
					next_st.thrChan  = wv[5:4];
				end
				`REG_THRLVL: begin
					wv               = merge({8'h0, st.thrLevel}, pwdata, pstrb);
					next_st.thrLevel = wv[`SAMPLE_W-1:0];
				end
				`REG_POSTCNT: next_st.postCount = merge(st.postCount, pwdata, pstrb);
				`REG_BUFLEN:  next_st.bufLen = merge(st.bufLen, pwdata, pstrb);
				// each write posts that many empty host buffers
				`REG_BUFPOST: begin
					wv               = merge(32'h0, pwdata, pstrb);
					next_st.bufAvail = st.bufAvail + wv[15:0];
				end
				`REG_STATUS: begin
					// write one to clear; a same-cycle event below wins
					wv = merge(32'h0, pwdata, pstrb);
					if (wv[`STAT_FULL]) begin
						next_st.fullFlag = 1'b0;
					end
					if (wv[`STAT_OVR]) begin
						next_st.ovrFlag = 1'b0;
					end
				end
				default: ;
			endcase
		end

		// trigger sequencer
		case (st.phase)
			ST_IDLE, ST_STOP: begin
				if (startCmd) begin
					// fresh run: empty fifo and counters
					next_st.wrPtr        = '0;
					next_st.rdPtr        = '0;
					next_st.count        = '0;
					next_st.headOk       = 1'b0;
					pop                  = 1'b0;
					next_st.ovrFlag      = 1'b0;
					next_st.bufFill      = '0;
					next_st.postDone     = '0;
					next_st.refPend      = 1'b0;
					next_st.thrPrevValid = 1'b0;
					next_st.pushLeft     = '0;
					if (st.startSrc == `SRC_SW && !st.slaveMode) begin
						next_st.phase       = ST_PRE; // R1
						next_st.syncTrigOut = 1'b1;
					end else begin
						next_st.phase = ST_ARMED;
					end
				end
			end
			ST_ARMED: begin
				if (st.slaveMode) begin
					startEv = syncEdge; // R8
				end else begin
					case (st.startSrc)
						`SRC_EXT:  startEv = extStartEv; // R2
						`SRC_THR:  startEv = scanTick & crossed(st.startPol, st.thrPrevValid,
							st.thrPrevAbove, st.thrPrevBelow, above, below); // R4
						`SRC_SYNC: startEv = syncEdge;
						default:   startEv = 1'b0;
					endcase
				end
				if (startEv) begin
					// later start events are ignored until the next run
					next_st.phase       = ST_PRE; // R22
					next_st.syncTrigOut = ~st.slaveMode;
				end
			end
			ST_PRE: begin
				if (scanTick) begin
					accept = 1'b1;
					// trigger scan stays pre-trigger; post begins with the next
					if (st.refSrc != `REF_NONE && (st.refPend || refNow || refLater)) begin
						next_st.refPend = 1'b0;
						next_st.phase   = (st.postCount == '0) ? ST_STOP : ST_POST; // R19
					end
				end else if (refLater) begin
					next_st.refPend = 1'b1; // R19
				end
			end
			ST_POST: begin
				if (scanTick) begin
					accept           = 1'b1;
					next_st.postDone = st.postDone + 32'h1; // R20
					if (st.postDone + 32'h1 >= st.postCount) begin
						next_st.phase = ST_STOP; // R20
					end
				end
			end
			default: next_st.phase = ST_IDLE;
		endcase

		// threshold history follows every scan while a stage may still fire
		if (scanTick && (st.phase == ST_ARMED || st.phase == ST_PRE)) begin
			next_st.thrPrevValid = 1'b1;
			next_st.thrPrevAbove = above;
			next_st.thrPrevBelow = below;
		end

		// store one listed channel per cycle into the fifo
		if (st.pushLeft != '0 && !st.ovrFlag) begin
			if (st.count == `FIFO_DEPTH) begin
				halt               = 1'b1;
				next_st.ovrFlag    = 1'b1; // R17
				next_st.overrunEvt = 1'b1; // R17
				next_st.phase      = ST_STOP; // R18
				next_st.pushLeft   = '0;
			end else begin
				push                                = 1'b1;
				memWe                               = 1'b1; // R16
				next_st.wrPtr                       = st.wrPtr + 1'b1;
				next_st.pushLeft[lowIdx(st.pushLeft)] = 1'b0; // R21
				if (st.bufFill + 32'h1 >= st.bufLen) begin
					next_st.bufFill       = '0;
					next_st.fullFlag      = 1'b1; // R13
					next_st.bufferFullEvt = 1'b1; // R13
					if (next_st.bufAvail <= 16'h1) begin
						halt             = 1'b1;
						next_st.bufAvail = '0;
						next_st.phase    = ST_STOP; // R14
						next_st.pushLeft = '0;
					end else begin
						next_st.bufAvail = next_st.bufAvail - 16'h1; // R14
					end
				end else begin
					next_st.bufFill = st.bufFill + 32'h1; // R14
				end
			end
		end
		// latch a whole scan; an undrained one means storage fell behind
		// the trigger scan and the last post scan are kept even though the
		// sequencer stops; only a storage stop or an abort drops the scan
		if (accept && !halt) begin
			if (st.pushLeft != '0) begin
				next_st.ovrFlag    = 1'b1; // R17
				next_st.overrunEvt = 1'b1;
				next_st.phase      = ST_STOP; // R18
				next_st.pushLeft   = '0;
			end else begin
				next_st.scan     = conv; // R21
				next_st.pushLeft = st.chanMask; // R21
			end
		end

		if (pop) begin
			next_st.rdPtr = st.rdPtr + 1'b1;
		end
		next_st.count = next_st.count + {{`FIFO_AW{1'b0}}, push} -
			{{`FIFO_AW{1'b0}}, pop};
		// abrupt stop discards the scan in flight
		if (abortCmd) begin
			next_st.phase    = ST_IDLE;
			next_st.pushLeft = '0;
			next_st.refPend  = 1'b0;
		end
		next_st.acqActive = (next_st.phase == ST_PRE) || (next_st.phase == ST_POST);
	end

	// single state register
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= `STATE_RST;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from the state register
	assign prdata        = st.prdata;
	assign pready        = st.pready;
	assign pslverr       = st.pslverr;
	assign syncTrigOut   = st.syncTrigOut;
	assign bufferFullEvt = st.bufferFullEvt;
	assign overrunEvt    = st.overrunEvt;
	assign acqActive     = st.acqActive;

endmodule

// ---- tb/acq_trig_monitor.sv ----
// port-level checks for the acquisition trigger control
// assumes it is bound onto the design top and shares its single clock mclk
`timescale 1ns/10ps
module acq_trig_monitor
	import acq_trig_pkg::*;
(
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	// apb slave side
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	// events and status
	input  wire logic        syncTrigOut,
	input  wire logic        bufferFullEvt,
	input  wire logic        overrunEvt,
	input  wire logic        acqActive
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	// first access cycle, answer not yet given
	sequence accessWait;
		psel && penable && !pready;
	endsequence
	// the slave answer
	sequence answer;
		pready;
	endsequence

	one_wait_a: assert property (accessWait |=> answer)
		else $error("apb answer not one cycle after access");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held over two cycles");
	unmapped_err_a: assert property (psel && penable && !pready && paddr > 8'h24
		|=> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
	err_with_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	full_pulse_a: assert property (bufferFullEvt |=> !bufferFullEvt)
		else $error("buffer full event longer than one cycle");
	overrun_stop_a: assert property (overrunEvt |=> (!overrunEvt && !acqActive) ##1 !acqActive)
		else $error("acquisition runs on after overrun");
	sync_out_run_a: assert property (syncTrigOut |-> ##[0:1] acqActive)
		else $error("link trigger out without a run");
	reset_quiet_a: assert property (disable iff (1'b0) sys_rst |=> !pready && !acqActive && !syncTrigOut)
		else $error("outputs active during reset");
endmodule

bind acquisition_trigger_control acq_trig_monitor i_mon (
	.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .syncTrigOut(syncTrigOut),
	.bufferFullEvt(bufferFullEvt), .overrunEvt(overrunEvt), .acqActive(acqActive));

// ---- tb/acq_far_side.sv ----
// model of the converter, trigger pin and link peer facing the block
// assumes callers enter its tasks just after a rising edge of mclk
`timescale 1ns/10ps
module acq_far_side
	import acq_trig_pkg::*;
(
	// clock
	input  wire logic mclk,
	// converter and trigger lines
	output logic      scanTick,
	output adc_scan_s adcScan,
	output logic      extTrig,
	output logic      syncLinkTrig
);
	// quiet lines at time zero
	initial begin
		scanTick = 1'b0;
		adcScan = '0;
		extTrig = 1'b0;
		syncLinkTrig = 1'b0;
	end
	// all channels converted together, then an idle gap
	task automatic tick(input adc_scan_s s, input int gap);
		scanTick <= 1'b1;
		adcScan  <= s;
		@(posedge mclk);
		scanTick <= 1'b0;
		adcScan  <= ~s; // stale data must never look valid
		repeat (gap) @(posedge mclk);
	endtask
	// pin level, held long enough for the resync chain
	task automatic setExt(input logic v);
		extTrig <= v;
		repeat (6) @(posedge mclk);
	endtask
	// one trigger from a linked module
	task automatic linkPulse();
		syncLinkTrig <= 1'b1;
		@(posedge mclk);
		syncLinkTrig <= 1'b0;
		repeat (4) @(posedge mclk);
	endtask
endmodule

// ---- tb/acquisition_trigger_control_bench.sv ----
// self-checking bench for the acquisition trigger control
// assumes acq_far_side as converter and link peer, apb driven from here
`timescale 1ns/10ps
`include "acq_trig_defines.svh"
`define CHECK_EQ(got, want) begin total_checks++; if ((got) !== (want)) begin \
	failures++; $display("Error at %0t: got %h want %h", $time, got, want); end end
module acquisition_trigger_control_bench
	import acq_trig_pkg::*;
;
	// raw converter word beside the code it must give
	typedef struct packed {
		logic [`RAW_W-1:0]    raw;
		logic [`SAMPLE_W-1:0] code;
	} row_s;
	row_s rows [6] = '{'{26'h0000000, 24'h800000}, '{26'h07FFFFF, 24'hFFFFFF},
		'{26'h1000000, 24'hFFFFFF}, '{26'h3800000, 24'h000000},
		'{26'h2000000, 24'h000000}, '{26'h0000001, 24'h800001}};
	logic        mclk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, lastErr;
	logic [7:0]  paddr = 8'h00;
	logic [3:0]  pstrb = 4'hF;
	logic [31:0] pwdata = 32'h0, prdata, rdata;
	logic        pready, pslverr, scanTick, extTrig, syncLinkTrig;
	logic        syncTrigOut, bufferFullEvt, overrunEvt, acqActive;
	adc_scan_s   adcScan, s;
	int          failures = 0, total_checks = 0, fulls = 0, ovrs = 0, syncOuts = 0;

	// free running clock
	always #50 mclk = ~mclk;
	// event pulses counted at the edge that samples them
	always @(posedge mclk) begin
		fulls    += (bufferFullEvt === 1'b1);
		ovrs     += (overrunEvt === 1'b1);
		syncOuts += (syncTrigOut === 1'b1);
	end

	acquisition_trigger_control i_dut (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .scanTick(scanTick),
		.adcScan(adcScan), .extTrig(extTrig), .syncLinkTrig(syncLinkTrig),
		.syncTrigOut(syncTrigOut), .bufferFullEvt(bufferFullEvt), .overrunEvt(overrunEvt),
		.acqActive(acqActive));
	acq_far_side i_far (.mclk(mclk), .scanTick(scanTick), .adcScan(adcScan),
		.extTrig(extTrig), .syncLinkTrig(syncLinkTrig));

	// verdict and end of run
	task automatic conclude();
		$display("checks %0d, mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// one apb transfer; request held until pready is seen high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			failures++;
			conclude();
		end
		rdata   = prdata;
		lastErr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask
	// read a register and compare it
	task automatic chk(input logic [7:0] a, input logic [31:0] want);
		apb(1'b0, a, 32'h0);
		`CHECK_EQ(rdata, want)
	endtask
	// end-of-test line
	task automatic note(input string n);
		$display("test %s done", n);
	endtask

	// main sequence
	initial begin
		s = '0;
		repeat (12) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		`CHECK_EQ(acqActive, 1'b0)
		chk(`REG_STATUS, 32'h0);
		apb(1'b0, 8'h30, 32'h0);
		`CHECK_EQ({lastErr, rdata}, 33'h100000000)
		note("reset");
		// free run, two buffers of one scan each, table of codes
		apb(1'b1, `REG_CHANCFG, 32'h7);
		apb(1'b1, `REG_BUFLEN, 32'h3);
		apb(1'b1, `REG_BUFPOST, 32'h2);
		apb(1'b1, `REG_TRIGCFG, 32'h0);
		apb(1'b1, `REG_CTRL, 32'h1);
		chk(`REG_STATUS, 32'h2);
		`CHECK_EQ(acqActive, 1'b1)
		for (int i = 0; i < 6; i += 3) begin
			s.raw = {rows[i+2].raw, rows[i+1].raw, rows[i].raw};
			i_far.tick(s, 8);
		end
		i_far.tick(s, 8); // no buffer left, scan dropped
		`CHECK_EQ(fulls, 2)
		chk(`REG_STATUS, 32'h14);
		chk(`REG_FIFOLVL, 32'h6);
		for (int i = 0; i < 6; i++) begin
			chk(`REG_FIFODATA, {8'h00, rows[i].code});
		end
		apb(1'b1, `REG_STATUS, 32'h30);
		chk(`REG_STATUS, 32'h4);
		note("codes");
		// external reference, two post scans
		s = '0;
		apb(1'b1, `REG_CHANCFG, 32'h1);
		apb(1'b1, `REG_BUFLEN, 32'h64);
		apb(1'b1, `REG_BUFPOST, 32'h1);
		apb(1'b1, `REG_POSTCNT, 32'h2);
		apb(1'b1, `REG_TRIGCFG, 32'h50);
		apb(1'b1, `REG_CTRL, 32'h1);
		repeat (2) i_far.tick(s, 8);
		i_far.setExt(1'b1);
		chk(`REG_STATUS, 32'h2);
		repeat (4) i_far.tick(s, 8);
		chk(`REG_FIFOLVL, 32'h5);
		chk(`REG_STATUS, 32'h4);
		i_far.setExt(1'b0);
		note("reference");
		// external start on falling edge only
		apb(1'b1, `REG_BUFPOST, 32'h1);
		apb(1'b1, `REG_TRIGCFG, 32'h01);
		apb(1'b1, `REG_CTRL, 32'h1);
		chk(`REG_STATUS, 32'h1);
		i_far.setExt(1'b1);
		chk(`REG_STATUS, 32'h1);
		i_far.setExt(1'b0);
		chk(`REG_STATUS, 32'h2);
		apb(1'b1, `REG_CTRL, 32'h2);
		note("ext start");
		// slave: pin ignored, link starts and references
		apb(1'b1, `REG_BUFPOST, 32'h1);
		apb(1'b1, `REG_TRIGCFG, 32'h33);
		apb(1'b1, `REG_POSTCNT, 32'h0);
		apb(1'b1, `REG_CTRL, 32'h5);
		chk(`REG_CTRL, 32'h4);
		i_far.setExt(1'b1);
		chk(`REG_STATUS, 32'h1);
		i_far.linkPulse();
		chk(`REG_STATUS, 32'h2);
		i_far.tick(s, 8);
		i_far.linkPulse();
		i_far.tick(s, 8);
		chk(`REG_STATUS, 32'h4);
		chk(`REG_FIFOLVL, 32'h2);
		`CHECK_EQ(syncOuts, 3)
		apb(1'b1, `REG_CTRL, 32'h2);
		i_far.setExt(1'b0);
		note("slave");
		// threshold start on rising crossing of channel one
		apb(1'b1, `REG_CHANCFG, 32'h13);
		apb(1'b1, `REG_THRLVL, 32'h900000);
		pstrb <= 4'h1;
		apb(1'b1, `REG_THRLVL, 32'h55);
		pstrb <= 4'hF;
		chk(`REG_THRLVL, 32'h900055);
		apb(1'b1, `REG_TRIGCFG, 32'h26);
		apb(1'b1, `REG_BUFPOST, 32'h1);
		apb(1'b1, `REG_CTRL, 32'h1);
		s = '0;
		i_far.tick(s, 8);
		s.raw[1] = 26'h0080000;
		i_far.tick(s, 8);
		chk(`REG_STATUS, 32'h1);
		s.raw[1] = 26'h0200000;
		i_far.tick(s, 8);
		chk(`REG_STATUS, 32'h2);
		s.raw[1] = 26'h0000000;
		i_far.tick(s, 8);
		chk(`REG_STATUS, 32'h4);
		chk(`REG_FIFOLVL, 32'h2);
		apb(1'b1, `REG_CTRL, 32'h2);
		note("threshold");
		// scans closer than the fifo can store them
		apb(1'b1, `REG_CHANCFG, 32'h7);
		apb(1'b1, `REG_TRIGCFG, 32'h0);
		apb(1'b1, `REG_BUFPOST, 32'h1);
		apb(1'b1, `REG_CTRL, 32'h1);
		i_far.tick(s, 1);
		i_far.tick(s, 8);
		`CHECK_EQ(ovrs, 1)
		chk(`REG_STATUS, 32'h24);
		chk(`REG_FIFODATA, 32'h0);
		note("overrun");
		conclude();
	end
endmodule
